/* File: rtl/hwmi_halt_wake.v */
/*
  Halt wake sequencer for maskable requests and macro service, with an
  AHB-Lite register slave.
  Assumes a CPU core that stops on cpu_clk_en low, takes one-cycle vector
  and resume pulses, and a macro service engine that answers ms_start
  with one ms_done pulse. All inputs are synchronous to clk_sys.
*/
// How it works
// - Only unmasked requests end the halt
// - Enabled and acceptable request vectors to its routine
// - Otherwise resume after the halting write
// - Accept if idle, lower level, or level-3 nesting
// - Equal or higher running: resume, and hold pending only if enabled
// - Pending request taken once acceptance holds
// - Macro service repeats until count end, ignoring enable
// - Count end, vector enable clear: wake normally
// - Count end, vector enable set: halt again
// - Enable and nesting both from the control register
// - Halt entered only by a write to standby with bit 0 set, of any size
`include "hwmi_map.vh"
`timescale 1ns/10ps
`default_nettype none

module hwmi_halt_wake (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        reset_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Interrupt sources and CPU status
  input  wire [7:0]  irq_req,
  input  wire        isr_active,
  input  wire [1:0]  isr_prio,
  // Macro service engine
  input  wire        ms_done,
  input  wire        ms_count_end,
  output wire        ms_start,
  output wire [2:0]  ms_src,
  // CPU core control
  output wire        cpu_clk_en,
  output wire        halted,
  output wire        vector_req,
  output wire [2:0]  vector_src,
  output wire        resume_next
);

  // ==========================================================
  // Functions

  // Lowest index wins among simultaneous requests
  function [2:0] first_set;
    input [7:0] vec;
    integer i;
    begin
      first_set = 3'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (vec[i]) begin
          first_set = i[2:0];
        end
      end
    end
  endfunction

  // Priority level of one source from the packed level register
  function [1:0] level_of;
    input [15:0] lv;
    input [2:0]  src;
    begin
      level_of = lv[{src, 1'b0} +: 2];
    end
  endfunction

  // Acceptance against the routine now running; lower number is higher
  function can_accept;
    input       act;
    input [1:0] act_lv;
    input [1:0] req_lv;
    input       nest;
    begin
      can_accept = !act || (req_lv < act_lv) ||
                   (!nest && act_lv == `HWMI_PRIO_LEVEL3 &&
                    req_lv == `HWMI_PRIO_LEVEL3);
    end
  endfunction

  // ==========================================================
  // Registers
  reg  [1:0]  ctrl_r;
  reg  [7:0]  mask_r;
  reg  [15:0] prio_r;
  reg  [7:0]  msel_r;
  reg  [7:0]  vce_r;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg         pend_r;
  reg         pend_nxt;
  reg  [2:0]  pend_src_r;
  reg  [2:0]  pend_src_nxt;
  reg  [2:0]  wake_src_r;
  reg  [2:0]  wake_src_nxt;
  reg         vec_r;
  reg         vec_nxt;
  reg  [2:0]  vec_src_r;
  reg  [2:0]  vec_src_nxt;
  reg         resume_r;
  reg         resume_nxt;
  reg         ms_start_r;
  reg         ms_start_nxt;
  reg  [2:0]  ms_src_r;
  reg  [2:0]  ms_src_nxt;
  reg  [31:0] rdata_r;
  reg         wr_pend_r;
  reg  [7:0]  wr_addr_r;

  // ==========================================================
  // Bus slave
  wire        addr_ph;
  wire        wr_ph;
  wire        halt_cmd;
  wire [7:0]  rd_addr;
  reg  [31:0] rd_mux;

  // Any NONSEQ or SEQ transfer counts; never stalls, always OKAY
  assign addr_ph   = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;
  assign wr_ph     = wr_pend_r;
  assign rd_addr   = haddr[7:0];

  // Only the low byte of a standby write carries the halt command
  assign halt_cmd = wr_ph && wr_addr_r == `HWMI_OFS_STBY &&
                    hwdata[`HWMI_STBY_HALT_BIT];

  // Read data chosen in the address phase so it comes from a flop
  always @* begin
    rd_mux = 32'h0000_0000;
    if (rd_addr == `HWMI_OFS_CTRL) begin
      rd_mux = {30'h0000_0000, ctrl_r};
    end else if (rd_addr == `HWMI_OFS_MASK) begin
      rd_mux = {24'h00_0000, mask_r};
    end else if (rd_addr == `HWMI_OFS_PRIO) begin
      rd_mux = {16'h0000, prio_r};
    end else if (rd_addr == `HWMI_OFS_MSEL) begin
      rd_mux = {24'h00_0000, msel_r};
    end else if (rd_addr == `HWMI_OFS_VCE) begin
      rd_mux = {24'h00_0000, vce_r};
    end else if (rd_addr == `HWMI_OFS_STAT) begin
      rd_mux = {23'h00_0000, wake_src_r, pend_src_r, pend_r, state_r};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Address phase capture and read data register
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_ph && hwrite;
      if (addr_ph) begin
        wr_addr_r <= haddr[7:0];
      end
      if (addr_ph && !hwrite) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Configuration writes land in the data phase
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= `HWMI_RST_CTRL;
      mask_r <= `HWMI_RST_MASK;
      prio_r <= `HWMI_RST_PRIO;
      msel_r <= `HWMI_RST_MSEL;
      vce_r  <= `HWMI_RST_VCE;
    end else if (wr_ph) begin
      if (wr_addr_r == `HWMI_OFS_CTRL) begin
        ctrl_r <= hwdata[1:0];
      end else if (wr_addr_r == `HWMI_OFS_MASK) begin
        mask_r <= hwdata[7:0];
      end else if (wr_addr_r == `HWMI_OFS_PRIO) begin
        prio_r <= hwdata[15:0];
      end else if (wr_addr_r == `HWMI_OFS_MSEL) begin
        msel_r <= hwdata[7:0];
      end else if (wr_addr_r == `HWMI_OFS_VCE) begin
        vce_r <= hwdata[7:0];
      end
    end
  end

  // ==========================================================
  // Wake decision
  wire        ie_flag;
  wire        nest_sel;
  wire [7:0]  live_req;
  wire        any_req;
  wire [2:0]  req_src;
  wire        req_ok;
  wire        ms_ok;
  wire        pend_ok;

  assign ie_flag  = ctrl_r[`HWMI_CTRL_IE_BIT];
  assign nest_sel = ctrl_r[`HWMI_CTRL_NEST_BIT];

  // Masked sources are invisible to the halt logic
  assign live_req = irq_req & ~mask_r;
  assign any_req  = |live_req;
  assign req_src  = first_set(live_req);
  assign req_ok   = can_accept(isr_active, isr_prio,
                               level_of(prio_r, req_src), nest_sel);
  assign ms_ok    = can_accept(isr_active, isr_prio,
                               level_of(prio_r, ms_src_r), nest_sel);
  assign pend_ok  = can_accept(isr_active, isr_prio,
                               level_of(prio_r, pend_src_r), nest_sel);

  // Sequencer: halt, macro service excursion, and the wake outcome.
  // The wake outcome is the same in both branches, so a macro count end
  // with vce clear behaves exactly like a plain request from the same source.
  always @* begin
    state_nxt    = state_r;
    pend_nxt     = pend_r;
    pend_src_nxt = pend_src_r;
    wake_src_nxt = wake_src_r;
    vec_nxt      = 1'b0;
    vec_src_nxt  = vec_src_r;
    resume_nxt   = 1'b0;
    ms_start_nxt = 1'b0;
    ms_src_nxt   = ms_src_r;
    case (state_r)
      `HWMI_ST_RUN: begin
        if (halt_cmd) begin
          state_nxt = `HWMI_ST_HALT;
        end else if (pend_r && ie_flag && pend_ok) begin
          vec_nxt     = 1'b1;
          vec_src_nxt = pend_src_r;
          pend_nxt    = 1'b0;
        end
      end
      `HWMI_ST_HALT: begin
        if (any_req && msel_r[req_src]) begin
          ms_start_nxt = 1'b1;
          ms_src_nxt   = req_src;
          state_nxt    = `HWMI_ST_MSVC;
        end else if (any_req) begin
          state_nxt    = `HWMI_ST_RUN;
          wake_src_nxt = req_src;
          if (ie_flag && req_ok) begin
            vec_nxt     = 1'b1;
            vec_src_nxt = req_src;
          end else begin
            resume_nxt = 1'b1;
            if (ie_flag) begin
              pend_nxt     = 1'b1;
              pend_src_nxt = req_src;
            end
          end
        end
      end
      `HWMI_ST_MSVC: begin
        if (ms_done && ms_count_end && !vce_r[ms_src_r]) begin
          state_nxt    = `HWMI_ST_RUN;
          wake_src_nxt = ms_src_r;
          if (ie_flag && ms_ok) begin
            vec_nxt     = 1'b1;
            vec_src_nxt = ms_src_r;
          end else begin
            resume_nxt = 1'b1;
            if (ie_flag) begin
              pend_nxt     = 1'b1;
              pend_src_nxt = ms_src_r;
            end
          end
        end else if (ms_done) begin
          state_nxt = `HWMI_ST_HALT;
        end
      end
      default: begin
        state_nxt = `HWMI_ST_RUN;
      end
    endcase
  end

  // Sequencer flops
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= `HWMI_ST_RUN;
      pend_r     <= 1'b0;
      pend_src_r <= 3'h0;
      wake_src_r <= 3'h0;
      vec_r      <= 1'b0;
      vec_src_r  <= 3'h0;
      resume_r   <= 1'b0;
      ms_start_r <= 1'b0;
      ms_src_r   <= 3'h0;
    end else begin
      state_r    <= state_nxt;
      pend_r     <= pend_nxt;
      pend_src_r <= pend_src_nxt;
      wake_src_r <= wake_src_nxt;
      vec_r      <= vec_nxt;
      vec_src_r  <= vec_src_nxt;
      resume_r   <= resume_nxt;
      ms_start_r <= ms_start_nxt;
      ms_src_r   <= ms_src_nxt;
    end
  end

  // ==========================================================
  // Core facing outputs
  // Clock runs during the macro excursion; that transfer needs the bus
  assign cpu_clk_en  = (state_r != `HWMI_ST_HALT);
  assign halted      = (state_r != `HWMI_ST_RUN);
  assign vector_req  = vec_r;
  assign vector_src  = vec_src_r;
  assign resume_next = resume_r;
  assign ms_start    = ms_start_r;
  assign ms_src      = ms_src_r;

endmodule // hwmi_halt_wake

`default_nettype wire

/* File: rtl/hwmi_map.vh */
/*
  Constant map of the halt wake block: register offsets, field positions,
  reset values and state codes.
  Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef HWMI_MAP_VH
`define HWMI_MAP_VH

// ==========================================================
// Register byte offsets
`define HWMI_OFS_CTRL      8'h00
`define HWMI_OFS_STBY      8'h04
`define HWMI_OFS_MASK      8'h08
`define HWMI_OFS_PRIO      8'h0C
`define HWMI_OFS_MSEL      8'h10
`define HWMI_OFS_VCE       8'h14
`define HWMI_OFS_STAT      8'h18

// ==========================================================
// Field positions
`define HWMI_CTRL_IE_BIT   0
`define HWMI_CTRL_NEST_BIT 1
`define HWMI_STBY_HALT_BIT 0
`define HWMI_STAT_PEND_BIT 2
`define HWMI_PRIO_LEVEL3   2'h3

// ==========================================================
// Reset values
`define HWMI_RST_CTRL      2'h0
`define HWMI_RST_MASK      8'hFF
`define HWMI_RST_PRIO      16'hFFFF
`define HWMI_RST_MSEL      8'h00
`define HWMI_RST_VCE       8'h00

// ==========================================================
// Sequencer state codes
`define HWMI_ST_RUN        2'h0
`define HWMI_ST_HALT       2'h1
`define HWMI_ST_MSVC       2'h2

// ==========================================================
// AHB-Lite encodings
`define HWMI_HTRANS_NONSEQ 2'h2
`define HWMI_HTRANS_SEQ    2'h3

`endif

/* File: tb/hwmi_ms_partner.sv */
/* Macro service engine model: one ms_done for each ms_start.
   Assumes ms_start is a one-cycle pulse on clk_sys. */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Engine model
module hwmi_ms_partner #(
  parameter N = 3
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Engine link
  input  wire logic ms_start,
  input  wire logic slow,
  output var  logic ms_done,
  output var  logic ms_count_end
);
  logic [3:0] dly_r;
  logic [7:0] cnt_r;
  logic       busy_r;
  // End flag toggles outside ms_done, so a stale value is never trusted
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dly_r <= 4'h0;
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
      ms_done <= 1'b0;
      ms_count_end <= 1'b0;
    end else begin
      ms_done <= 1'b0;
      if (ms_start) begin
        busy_r <= 1'b1;
        dly_r <= slow ? 4'h5 : 4'h0;
      end else if (busy_r && dly_r != 4'h0) begin
        dly_r <= dly_r - 4'h1;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        ms_done <= 1'b1;
        ms_count_end <= (cnt_r + 8'h01 == N);
        cnt_r <= (cnt_r + 8'h01 == N) ? 8'h00 : cnt_r + 8'h01;
      end else begin
        ms_count_end <= ~ms_count_end;
      end
    end
  end
endmodule // hwmi_ms_partner
`default_nettype wire

/* File: tb/hwmi_props.sv */
/* Port checker for the halt wake block.
   Assumes one clk_sys domain; bound onto hwmi_halt_wake. */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Wake outcome relations
module hwmi_props (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // Observed ports
  input wire logic [7:0] irq_req,
  input wire logic       ms_done,
  input wire logic       ms_start,
  input wire logic       cpu_clk_en,
  input wire logic       halted,
  input wire logic       vector_req,
  input wire logic       resume_next
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_vec_single: assert property (vector_req |=> !vector_req)
    else $error("vector pulse too long");
  a_vec_awake: assert property (vector_req |-> !halted && cpu_clk_en)
    else $error("vector while halted");
  a_res_single: assert property (resume_next |=> !resume_next)
    else $error("resume pulse too long");
  a_one_outcome: assert property (!(vector_req && resume_next))
    else $error("vector and resume together");
  a_ms_halted: assert property (ms_start |-> halted && !vector_req)
    else $error("macro start outside halt");
  a_ms_spaced: assert property (ms_start |=> (!ms_start) [*2])
    else $error("macro starts too close");
  a_wake_cause: assert property ($fell(halted) |-> $past(irq_req) != 8'h00)
    else $error("wake without request");
  a_clk_back: assert property ($fell(halted) |-> cpu_clk_en)
    else $error("clock not back on wake");
  // Halt is only ever entered from run, so the core clock must stop with it
  a_clk_stop: assert property ($rose(halted) |-> !cpu_clk_en)
    else $error("clock still running on halt entry");
  a_halt_hold: assert property (halted && irq_req == 8'h00 && !ms_done |=> halted)
    else $error("halt left without cause");
endmodule // hwmi_props

bind hwmi_halt_wake hwmi_props hwmi_props_u (.clk_sys(clk_sys), .reset_n(reset_n),
  .irq_req(irq_req), .ms_done(ms_done), .ms_start(ms_start), .cpu_clk_en(cpu_clk_en),
  .halted(halted), .vector_req(vector_req), .resume_next(resume_next));
`default_nettype wire

/* File: tb/tb.sv */
/* Self-checking bench for the halt wake block.
   Assumes the macro engine model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
`include "hwmi_map.vh"
`define CHK(g,e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
// ==========================================================
// Bench top
module tb;
  logic        clk_sys, reset_n, hsel, hwrite, hreadyout, hresp, isr_active;
  logic        ms_done, ms_count_end, ms_start, cpu_clk_en, halted, slow;
  logic        vector_req, resume_next, rd_take, vce_on;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [1:0]  htrans, isr_prio;
  logic [7:0]  irq_req;
  logic [2:0]  ms_src, vector_src;
  logic [31:0] q[$];
  logic [6:0]  cs [0:6] = '{7'h40, 7'h00, 7'h56, 7'h5F, 7'h7F, 7'h59, 7'h55};
  int          fail_count, n_compared;

  hwmi_halt_wake dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req),
    .isr_active(isr_active), .isr_prio(isr_prio), .ms_done(ms_done),
    .ms_count_end(ms_count_end), .ms_start(ms_start), .ms_src(ms_src),
    .cpu_clk_en(cpu_clk_en), .halted(halted), .vector_req(vector_req),
    .vector_src(vector_src), .resume_next(resume_next));
  hwmi_ms_partner #(.N(3)) ptn_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .ms_start(ms_start), .slow(slow), .ms_done(ms_done), .ms_count_end(ms_count_end));

  // Clock at 40 MHz
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // One AHB-Lite single transfer; read data taken at the data-phase edge
  task automatic xfer(input logic wr, input [7:0] a, input [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1; htrans <= `HWMI_HTRANS_NONSEQ; haddr <= {24'h0000_00, a}; hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d; rd_take <= !wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd_take <= 1'b0;
  endtask
  task automatic br(input [7:0] a, input [31:0] e);
    q.push_back(e);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  task automatic take(input [31:0] got);
    logic [31:0] e;
    e = q.size() ? q.pop_front() : 32'hDEAD_BEEF;
    `CHK(got, e)
  endtask
  task automatic wq;
    int k;
    k = 0;
    while (q.size() != 0 && k < 400) begin
      @(posedge clk_sys);
      k++;
    end
    if (q.size() != 0) begin
      fail_count++;
      q.delete();
    end
  endtask

  // Masked first, then unmasked; outcome from enable and priorities
  task automatic run_case(input [6:0] c, input [2:0] s);
    logic ie, nest, act, acc;
    logic [1:0] ap, rp;
    {ie, nest, act, ap, rp} = c;
    acc = !act || rp < ap || (rp == 2'h3 && ap == 2'h3 && !nest);
    xfer(1'b1, `HWMI_OFS_MASK, 32'h0000_00FF);
    xfer(1'b1, `HWMI_OFS_CTRL, {30'h0, nest, ie});
    br(`HWMI_OFS_CTRL, {30'h0, nest, ie});
    xfer(1'b1, `HWMI_OFS_PRIO, (32'h0000_FFFF & ~(32'h3 << (2 * s))) | ({30'h0, rp} << (2 * s)));
    isr_active <= act;
    isr_prio <= ap;
    xfer(1'b1, `HWMI_OFS_STBY, 32'h0000_0001);
    irq_req[s] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    `CHK(halted, 1'b1)
    `CHK(cpu_clk_en, 1'b0)
    q.push_back((ie && acc) ? (32'h0000_0100 | s) : 32'h0000_0200);
    xfer(1'b1, `HWMI_OFS_MASK, 32'h0000_00FF & ~(32'h1 << s));
    wq;
    if (ie && !acc) begin
      q.push_back(32'h0000_0100 | s);
      isr_active <= 1'b0;
      wq;
    end
    irq_req <= 8'h00;
    isr_active <= 1'b0;
  endtask

  // Three transfers with enable off, then wake or halt again by vce
  task automatic mrun(input logic vce, input [2:0] s);
    // The previous case left only its own source unmasked
    xfer(1'b1, `HWMI_OFS_MASK, 32'h0000_00FF & ~(32'h1 << s));
    xfer(1'b1, `HWMI_OFS_CTRL, 32'h0000_0000);
    xfer(1'b1, `HWMI_OFS_MSEL, 32'h1 << s);
    xfer(1'b1, `HWMI_OFS_VCE, {31'h0, vce} << s);
    vce_on = vce;
    repeat (3) q.push_back(32'h0000_0300 | s);
    if (!vce) q.push_back(32'h0000_0200);
    xfer(1'b1, `HWMI_OFS_STBY, 32'h0000_0001);
    irq_req[s] <= 1'b1;
    wq;
    repeat (10) @(posedge clk_sys);
    `CHK(halted, vce)
    `CHK(cpu_clk_en, !vce)
    irq_req <= 8'h00;
    if (vce) begin
      xfer(1'b1, `HWMI_OFS_MSEL, 32'h0000_0000);
      xfer(1'b1, `HWMI_OFS_CTRL, 32'h0000_0001);
      q.push_back(32'h0000_0100 | s);
      irq_req[s] <= 1'b1;
      wq;
      irq_req <= 8'h00;
    end
    vce_on = 1'b0;
  endtask

  // A source stops asking once its final transfer with vce set is done
  always @(posedge clk_sys) if (vce_on && ms_done && ms_count_end) irq_req <= 8'h00;

  // Each result at the outputs retires the oldest note
  always @(posedge clk_sys) begin
    if (rd_take) take(hrdata);
    if (vector_req === 1'b1) take(32'h0000_0100 | vector_src);
    if (resume_next === 1'b1) take(32'h0000_0200);
    if (ms_start === 1'b1) take(32'h0000_0300 | ms_src);
  end

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    end_of_test;
  end

  // Main sequence
  initial begin
    {reset_n, hsel, hwrite, htrans, haddr, hwdata, isr_active, isr_prio} = '0;
    {irq_req, rd_take, vce_on, slow} = '0;
    rnd = 32'h5ffa_870e;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    br(`HWMI_OFS_CTRL, 32'h0000_0000);
    br(`HWMI_OFS_MASK, 32'h0000_00FF);
    br(`HWMI_OFS_PRIO, 32'h0000_FFFF);
    br(`HWMI_OFS_MSEL, 32'h0000_0000);
    br(`HWMI_OFS_VCE, 32'h0000_0000);
    br(`HWMI_OFS_STAT, 32'h0000_0000);
    br(8'h40, 32'h0000_0000);
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
    for (int i = 0; i < 7; i++) begin
      rnd = lfsr(rnd);
      slow <= rnd[3];
      run_case(cs[i], rnd[2:0]);
    end
    mrun(1'b0, rnd[6:4]);
    slow <= 1'b1;
    mrun(1'b1, rnd[9:7]);
    end_of_test;
  end
endmodule // tb
`default_nettype wire
